// >>> dadc_sequencer.sv
// Functional notes
// - speed bit 0 gives 266 states max first conversion, 1 gives 134.
// - control/status bit 2 reads 0; software writes 0.
// - single mode: channel bits pick one of the unit's four inputs.
// - scan mode: channel bits 00..11 scan the first one to four inputs.
// - power-on reset and standby load trigger register with 0x7F.
// - trigger enable 1 lets pin falling edge or timer trigger start.
// - trigger pin and timer shared; enable is OR of both units.
// - trigger register bits 6..0 read 1; software writes 1.
// - upper byte read returns directly and latches lower byte for later.
// - each unit converts by 10-bit successive approximation.
// - single mode start bit holds during conversion, self clears at end.
// - result stored in the register of the converted input.
// - end flag set at conversion or scan end; irq when flag and enable.
// - end flag clears only by writing 0 after reading it as 1.
// - new mode or channel accepted in the write that sets start.
// - scan converts inputs ascending, each starting right after the last.
// - scan repeats while start is 1; restart begins at first input.
// - start delay 10..17 states at speed 0, 6..9 at speed 1.
// - first conversion 259..266 / 131..134; later ones 256 / 128 exactly.
// - result left-aligned in 16 bits, low bits 5..0 read 0.
// - inputs 0..3 go to unit 0 registers, 4..7 to unit 1.
`timescale 1ns/100ps
`default_nettype none
`include "dadc_params.svh"

module dadc_sequencer
   import dadc_pkg::*;
#(
   parameter int RES_BITS = 10,
   parameter int NUM_UNITS = 2
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic standby_i,
   // 8-bit internal cpu bus
   input wire logic [`DADC_ADDR_W-1:0] bus_addr_i,
   input wire logic bus_rd_i,
   input wire logic bus_wr_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   // triggers
   input wire logic external_trigger_pin_n_i,
   input wire logic timer_unit_trigger_i,
   // analog front end, one entry per unit
   input wire logic [NUM_UNITS-1:0] comp_i,
   output dadc_afe_s [NUM_UNITS-1:0] afe_o,
   // completion interrupt requests
   output logic [NUM_UNITS-1:0] completion_interrupt_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the register layout only holds a 10-bit result in a 16-bit word
   if (RES_BITS != 10) begin : g_bad_res
      $error("dadc_sequencer: RES_BITS must be 10");
   end
   if (NUM_UNITS != 2) begin : g_bad_units
      $error("dadc_sequencer: NUM_UNITS must be 2");
   end

   // ----------------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------------
   // data byte address: {0, unit, channel[1:0], low}
   function automatic logic is_data(input logic [`DADC_ADDR_W-1:0] a);
      return (a & 5'h10) == `DADC_OFS_DATA_BASE;
   endfunction

   function automatic logic is_csr(input logic [`DADC_ADDR_W-1:0] a, input logic u);
      return a == (u ? `DADC_OFS_CSR1 : `DADC_OFS_CSR0);
   endfunction

   function automatic logic is_trg(input logic [`DADC_ADDR_W-1:0] a, input logic u);
      return a == (u ? `DADC_OFS_TRG1 : `DADC_OFS_TRG0);
   endfunction

   // ----------------------------------------------------------------
   // shared trigger logic
   // ----------------------------------------------------------------
   logic pin_q, pin_d;
   logic [2:0] phase_q, phase_d;
   logic [NUM_UNITS-1:0] trg_en;
   logic trig_start;

   // pin is synchronous; falling edge is the first transition of a low pulse
   always_comb begin
      pin_d = external_trigger_pin_n_i;
      phase_d = phase_q + 3'h1;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pin_q <= 1'b1;
         phase_q <= 3'h0;
      end else begin
         pin_q <= pin_d;
         phase_q <= phase_d;
      end
   end

   // both units see the same trigger, gated by either enable
   assign trig_start = (|trg_en) && ((pin_q && !external_trigger_pin_n_i) || timer_unit_trigger_i);

   // ----------------------------------------------------------------
   // converter units
   // ----------------------------------------------------------------
   logic [NUM_UNITS-1:0][7:0] csr_rd;
   logic [NUM_UNITS-1:0][7:0] temp_rd;
   logic [NUM_UNITS-1:0][3:0][RES_BITS-1:0] res_rd;

   for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      dadc_csr_s csr_q, csr_d;
      logic trig_en_q, trig_en_d;
      logic seen_q, seen_d;
      dadc_state_e st_q, st_d;
      logic [8:0] cnt_q, cnt_d;
      logic [1:0] chan_q, chan_d;
      logic first_q, first_d;
      logic [3:0][RES_BITS-1:0] res_q, res_d;
      logic [7:0] temp_q, temp_d;
      logic sar_start, sar_step;
      logic [RES_BITS-1:0] sar_code;
      logic wr_csr, rd_csr, wr_trg, rd_hi;
      logic [1:0] group_last;
      logic [2:0] align_mask;
      logic [8:0] step_mask;
      logic [8:0] td_load, gap_load, spl_load, conv_load;

      assign wr_csr = bus_wr_i && is_csr(bus_addr_i, 1'(u));
      assign rd_csr = bus_rd_i && is_csr(bus_addr_i, 1'(u));
      assign wr_trg = bus_wr_i && is_trg(bus_addr_i, 1'(u));
      assign rd_hi = bus_rd_i && is_data(bus_addr_i) && (bus_addr_i[3] == 1'(u)) && !bus_addr_i[0];
      assign group_last = {csr_q.channel_select_high, csr_q.channel_select_low};

      // phase lengths by speed; counters load length minus one, the delay loads its minimum minus three
      always_comb begin
         if (csr_q.speed_select) begin
            td_load = `DADC_TD_MIN_S1 - 9'h003;
            gap_load = `DADC_GAP_S1 - 9'h001;
            spl_load = `DADC_SPL_S1 - 9'h001;
            conv_load = `DADC_CONV_S1 - 9'h001;
            align_mask = `DADC_ALIGN_S1;
            step_mask = `DADC_STEP_MASK_S1;
         end else begin
            td_load = `DADC_TD_MIN_S0 - 9'h003;
            gap_load = `DADC_GAP_S0 - 9'h001;
            spl_load = `DADC_SPL_S0 - 9'h001;
            conv_load = `DADC_CONV_S0 - 9'h001;
            align_mask = `DADC_ALIGN_S0;
            step_mask = `DADC_STEP_MASK_S0;
         end
      end

      assign sar_start = (st_q == DADC_SAMPLE) && (cnt_q == 9'h000);
      assign sar_step = (st_q == DADC_CONVERT) && ((cnt_q & step_mask) == 9'h000);

      // registers and sequencer next state
      always_comb begin
         csr_d = csr_q;
         trig_en_d = trig_en_q;
         seen_d = seen_q;
         st_d = st_q;
         cnt_d = cnt_q;
         chan_d = chan_q;
         first_d = first_q;
         res_d = res_q;
         temp_d = temp_q;
         // cpu side
         if (rd_csr && csr_q.conversion_end_flag) begin
            seen_d = 1'b1;
         end
         if (wr_csr) begin
            // mode, speed and channel are taken even mid-conversion; user must stop first
            csr_d.end_interrupt_enable = bus_wdata_i[6];
            csr_d.start = bus_wdata_i[5];
            csr_d.scan = bus_wdata_i[4];
            csr_d.speed_select = bus_wdata_i[3];
            csr_d.channel_select_high = bus_wdata_i[1];
            csr_d.channel_select_low = bus_wdata_i[0];
            if (!bus_wdata_i[`DADC_CSR_FLAG_BIT] && seen_q) begin
               csr_d.conversion_end_flag = 1'b0;
            end
            seen_d = 1'b0;
         end
         if (wr_trg) begin
            trig_en_d = bus_wdata_i[`DADC_TRG_EN_BIT];
         end
         if (rd_hi) begin
            temp_d = {res_q[bus_addr_i[2:1]][1:0], `DADC_RES_LSB_ALIGN};
         end
         if (trig_start) begin
            csr_d.start = 1'b1;
         end
         // sequencer
         case (st_q)
            DADC_IDLE: begin
               if (csr_q.start) begin
                  // selection as it stands when the start bit went high
                  chan_d = csr_q.scan ? 2'h0 : group_last;
                  cnt_d = td_load;
                  first_d = 1'b1;
                  st_d = DADC_DELAY;
               end
            end
            DADC_DELAY: begin
               cnt_d = cnt_q - 9'h001;
               if (cnt_q == 9'h000) begin
                  cnt_d = spl_load;
                  st_d = first_q ? DADC_ALIGN : DADC_SAMPLE;
               end
            end
            DADC_ALIGN: begin
               // waits for the prescaler phase, so the delay depends on write timing
               if ((phase_q & align_mask) == 3'h0) begin
                  cnt_d = spl_load;
                  st_d = DADC_SAMPLE;
               end
            end
            DADC_SAMPLE: begin
               cnt_d = cnt_q - 9'h001;
               if (cnt_q == 9'h000) begin
                  cnt_d = conv_load;
                  st_d = DADC_CONVERT;
               end
            end
            DADC_CONVERT: begin
               cnt_d = cnt_q - 9'h001;
               if (cnt_q == 9'h000) begin
                  res_d[chan_q] = sar_code;
                  first_d = 1'b0;
                  if (!csr_q.scan) begin
                     csr_d.conversion_end_flag = 1'b1;
                     csr_d.start = 1'b0;
                     st_d = DADC_IDLE;
                  end else begin
                     if (chan_q == group_last) begin
                        csr_d.conversion_end_flag = 1'b1;
                        chan_d = 2'h0;
                     end else begin
                        chan_d = chan_q + 2'h1;
                     end
                     cnt_d = gap_load;
                     st_d = DADC_DELAY;
                  end
               end
            end
            default: begin
               st_d = DADC_IDLE;
            end
         endcase
         // clearing start aborts; a later set restarts from the first input
         if (st_q != DADC_IDLE && !csr_q.start) begin
            st_d = DADC_IDLE;
         end
         // standby initialises registers, results and state like power-on reset, not the counters or read data
         if (standby_i) begin
            csr_d = `DADC_CSR_RST;
            trig_en_d = 1'(`DADC_TRG_RST >> `DADC_TRG_EN_BIT);
            seen_d = 1'b0;
            st_d = DADC_IDLE;
            res_d = '0;
            temp_d = 8'h00;
         end
      end

      always_ff @(posedge clk_sys_i) begin
         if (sys_rst_i) begin
            csr_q <= `DADC_CSR_RST;
            trig_en_q <= 1'(`DADC_TRG_RST >> `DADC_TRG_EN_BIT);
            seen_q <= 1'b0;
            st_q <= DADC_IDLE;
            cnt_q <= 9'h000;
            chan_q <= 2'h0;
            first_q <= 1'b0;
            res_q <= '0;
            temp_q <= 8'h00;
         end else begin
            csr_q <= csr_d;
            trig_en_q <= trig_en_d;
            seen_q <= seen_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            chan_q <= chan_d;
            first_q <= first_d;
            res_q <= res_d;
            temp_q <= temp_d;
         end
      end

      // successive approximation register
      dadc_sar #(
         .RES_BITS(RES_BITS)
      ) u_sar (
         .clk_sys_i(clk_sys_i),
         .sys_rst_i(sys_rst_i),
         .start_i(sar_start),
         .step_i(sar_step),
         .comp_i(comp_i[u]),
         .code_o(sar_code),
         .done_o()
      );

      // read views and front-end drive
      always_comb begin
         csr_rd[u] = csr_q;
         csr_rd[u][2] = 1'b0;
      end
      assign temp_rd[u] = temp_q;
      assign res_rd[u] = res_q;
      assign trg_en[u] = trig_en_q;
      assign afe_o[u].sample = (st_q == DADC_SAMPLE);
      assign afe_o[u].chan = chan_q;
      assign afe_o[u].dac = sar_code;
      assign completion_interrupt_o[u] = csr_q.conversion_end_flag && csr_q.end_interrupt_enable;
   end

   // ----------------------------------------------------------------
   // read data mux, registered
   // ----------------------------------------------------------------
   logic [7:0] rdata_q, rdata_d;

   // lower byte comes from the latch, so upper-then-lower is consistent
   always_comb begin
      rdata_d = rdata_q;
      if (bus_rd_i) begin
         rdata_d = 8'h00;
         if (is_data(bus_addr_i)) begin
            if (bus_addr_i[0]) begin
               rdata_d = temp_rd[bus_addr_i[3]];
            end else begin
               rdata_d = res_rd[bus_addr_i[3]][bus_addr_i[2:1]][RES_BITS-1:2];
            end
         end else begin
            for (int k = 0; k < NUM_UNITS; k++) begin
               if (is_csr(bus_addr_i, k[0])) begin
                  rdata_d = csr_rd[k];
               end
               if (is_trg(bus_addr_i, k[0])) begin
                  rdata_d = {trg_en[k], `DADC_TRG_RSV_ONES};
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign bus_rdata_o = rdata_q;

endmodule

`default_nettype wire

// >>> dadc_params.svh
`ifndef DADC_PARAMS_SVH
`define DADC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets on the 8-bit internal bus (5 low address bits)
// ----------------------------------------------------------------
`define DADC_ADDR_W 5
`define DADC_OFS_DATA_BASE 5'h00
`define DADC_OFS_CSR0 5'h10
`define DADC_OFS_CSR1 5'h11
`define DADC_OFS_TRG0 5'h12
`define DADC_OFS_TRG1 5'h13

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define DADC_CSR_RST 8'h00
`define DADC_TRG_RST 8'h7F
`define DADC_TRG_RSV_ONES 7'h7F
`define DADC_CSR_FLAG_BIT 7
`define DADC_TRG_EN_BIT 7
`define DADC_RES_LSB_ALIGN 6'h00

// ----------------------------------------------------------------
// timing in states (one state = one clk_sys_i cycle)
// ----------------------------------------------------------------
`define DADC_TCONV_MAX_S0 9'h10A
`define DADC_TCONV_MAX_S1 9'h086
`define DADC_TD_MIN_S0 9'h00A
`define DADC_TD_MAX_S0 9'h011
`define DADC_TD_MIN_S1 9'h006
`define DADC_TD_MAX_S1 9'h009
`define DADC_SPL_S0 9'h040
`define DADC_SPL_S1 9'h020
`define DADC_TNEXT_S0 9'h100
`define DADC_TNEXT_S1 9'h080
`define DADC_CONV_S0 (`DADC_TCONV_MAX_S0 - `DADC_TD_MAX_S0 - `DADC_SPL_S0)
`define DADC_CONV_S1 (`DADC_TCONV_MAX_S1 - `DADC_TD_MAX_S1 - `DADC_SPL_S1)
`define DADC_GAP_S0 (`DADC_TNEXT_S0 - `DADC_SPL_S0 - `DADC_CONV_S0)
`define DADC_GAP_S1 (`DADC_TNEXT_S1 - `DADC_SPL_S1 - `DADC_CONV_S1)
`define DADC_ALIGN_S0 3'h7
`define DADC_ALIGN_S1 3'h3
`define DADC_STEP_MASK_S0 9'h00F
`define DADC_STEP_MASK_S1 9'h007

`endif

// >>> dadc_pkg.sv
package dadc_pkg;

   // conversion sequencer states, gray along idle-delay-align-sample-convert
   typedef enum logic [2:0] {
      DADC_IDLE = 3'h0,
      DADC_DELAY = 3'h1,
      DADC_ALIGN = 3'h3,
      DADC_SAMPLE = 3'h2,
      DADC_CONVERT = 3'h6
   } dadc_state_e;

   // control/status register layout
   typedef struct packed {
      logic conversion_end_flag;
      logic end_interrupt_enable;
      logic start;
      logic scan;
      logic speed_select;
      logic rsv;
      logic channel_select_high;
      logic channel_select_low;
   } dadc_csr_s;

   // per-unit analog front-end controls
   typedef struct packed {
      logic sample;
      logic [1:0] chan;
      logic [9:0] dac;
   } dadc_afe_s;

endpackage

// >>> dadc_sar.sv
`timescale 1ns/100ps
`default_nettype none

module dadc_sar
   import dadc_pkg::*;
#(
   parameter int RES_BITS = 10
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // control
   input wire logic start_i,
   input wire logic step_i,
   input wire logic comp_i,
   // result
   output logic [RES_BITS-1:0] code_o,
   output logic done_o
);

   logic [RES_BITS-1:0] code_q, code_d;
   logic [RES_BITS-1:0] trial_q, trial_d;
   logic done_q, done_d;

   // one bit decided per step, msb first; comp_i high keeps the trial bit
   always_comb begin
      code_d = code_q;
      trial_d = trial_q;
      done_d = done_q;
      if (start_i) begin
         trial_d = {1'b1, {(RES_BITS-1){1'b0}}};
         code_d = trial_d;
         done_d = 1'b0;
      end else if (step_i && !done_q) begin
         if (!comp_i) begin
            code_d = code_q & ~trial_q;
         end
         trial_d = trial_q >> 1;
         code_d = code_d | trial_d;
         done_d = trial_q[0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         code_q <= '0;
         trial_q <= '0;
         done_q <= 1'b0;
      end else begin
         code_q <= code_d;
         trial_q <= trial_d;
         done_q <= done_d;
      end
   end

   assign code_o = code_q;
   assign done_o = done_q;

endmodule

`default_nettype wire

// >>> dadc_sequencer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "dadc_params.svh"

module dadc_sequencer_asserts
   import dadc_pkg::*;
#(
   parameter int RES_BITS = 10,
   parameter int NUM_UNITS = 2
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic standby_i,
   // cpu bus
   input wire logic [`DADC_ADDR_W-1:0] bus_addr_i,
   input wire logic bus_rd_i,
   input wire logic bus_wr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic [7:0] bus_rdata_o,
   // triggers, front end, interrupts
   input wire logic external_trigger_pin_n_i,
   input wire logic timer_unit_trigger_i,
   input wire logic [NUM_UNITS-1:0] comp_i,
   input wire dadc_afe_s [NUM_UNITS-1:0] afe_o,
   input wire logic [NUM_UNITS-1:0] completion_interrupt_o
);
   // --------------------------------------------------------
   // sampling run length and sample-to-sample spacing, unit 0
   // --------------------------------------------------------
   logic [8:0] spl_q, spl_d, gap_q, gap_d;
   logic prev_q, prev_d;

   // gap saturates so an idle unit never looks like a short period
   always_comb begin
      prev_d = afe_o[0].sample;
      spl_d = afe_o[0].sample ? spl_q + 9'h001 : 9'h000;
      gap_d = (gap_q == 9'h1FF) ? gap_q : gap_q + 9'h001;
      if (afe_o[0].sample && !prev_q) begin
         gap_d = 9'h000;
      end
   end

   // counters restart with every reset or standby
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || standby_i) begin
         spl_q <= 9'h000;
         gap_q <= 9'h1FF;
         prev_q <= 1'b0;
      end else begin
         spl_q <= spl_d;
         gap_q <= gap_d;
         prev_q <= prev_d;
      end
   end

   // --------------------------------------------------------
   // properties
   // --------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i || standby_i);

   a_csr_rsv_zero: assert property (bus_rd_i && bus_addr_i[4:1] == 4'h8 |=> bus_rdata_o[2] == 1'b0)
      else $error("control status bit 2 read as one");
   a_trg_rsv_ones: assert property (bus_rd_i && bus_addr_i[4:1] == 4'h9 |=> bus_rdata_o[6:0] == 7'h7F)
      else $error("trigger control low bits not all ones");
   a_res_low_zero: assert property (bus_rd_i && !bus_addr_i[4] && bus_addr_i[0] |=> bus_rdata_o[5:0] == 6'h00)
      else $error("result low byte bits 5..0 not zero");
   a_rdata_stands: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
      else $error("read data moved without a read");
   a_flag_clear_cause: assert property ($fell(completion_interrupt_o[0]) |-> $past(bus_wr_i) && $past(bus_addr_i) == 5'h10)
      else $error("end flag cleared without a status write");
   a_irq_after_conv: assert property ($rose(completion_interrupt_o[0]) |-> !afe_o[0].sample || $past(bus_wr_i))
      else $error("interrupt raised while sampling");
   a_sample_len: assert property ($fell(afe_o[0].sample) && !$past(bus_wr_i, 2) |-> spl_q == 9'h020 || spl_q == 9'h040)
      else $error("sampling interval length wrong");
   a_scan_period: assert property ($rose(afe_o[0].sample) |-> gap_q >= 9'h07F)
      else $error("conversions closer than 128 states");

   c_irq0: cover property ($rose(completion_interrupt_o[0]));
   c_irq1: cover property ($rose(completion_interrupt_o[1]));
   c_sample_end: cover property ($fell(afe_o[0].sample));
endmodule

bind dadc_sequencer dadc_sequencer_asserts #(.RES_BITS(RES_BITS), .NUM_UNITS(NUM_UNITS)) i_chk (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .standby_i(standby_i),
   .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i),
   .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
   .external_trigger_pin_n_i(external_trigger_pin_n_i), .timer_unit_trigger_i(timer_unit_trigger_i),
   .comp_i(comp_i), .afe_o(afe_o), .completion_interrupt_o(completion_interrupt_o)
);
`default_nettype wire

// >>> dadc_afe_model.sv
`timescale 1ns/100ps
`default_nettype none

module dadc_afe_model
   import dadc_pkg::*;
(
   // clock
   input wire logic clk_sys_i,
   // front end controls and comparator answers
   input wire dadc_afe_s [1:0] afe_i,
   output logic [1:0] comp_o
);
   logic [9:0] held_q [2];

   // sample and hold: level per input is {unit, channel, 7'h5A}, frozen after sampling
   always_ff @(posedge clk_sys_i) begin
      for (int u = 0; u < 2; u++) begin
         if (afe_i[u].sample) begin
            held_q[u] <= {u[0], afe_i[u].chan, 7'h5A};
         end
      end
   end

   // comparator keeps the trial bit while the held level is at or above it
   always_comb begin
      for (int u = 0; u < 2; u++) begin
         comp_o[u] = (held_q[u] >= afe_i[u].dac);
      end
   end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dadc_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t %h %h", $time, g, e); end end

module tb;
   import dadc_pkg::*;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, standby = 1'b0, rd = 1'b0, wr = 1'b0;
   logic pin_n = 1'b1, tmr = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00, rdata;
   logic [1:0] comp, irq;
   dadc_afe_s [1:0] afe;
   int n_errors = 0, compares = 0, n;

   dadc_sequencer i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .standby_i(standby),
      .bus_addr_i(addr), .bus_rd_i(rd), .bus_wr_i(wr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
      .external_trigger_pin_n_i(pin_n), .timer_unit_trigger_i(tmr), .comp_i(comp), .afe_o(afe),
      .completion_interrupt_o(irq));
   dadc_afe_model i_afe (.clk_sys_i(clk_sys_i), .afe_i(afe), .comp_o(comp));

   // 200 MHz system clock
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   // ------------------------------------------------------------
   // bus and helper tasks, inputs change on the falling edge
   // ------------------------------------------------------------
   task automatic wrb(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys_i);
      wr = 1'b0;
   endtask
   task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
      @(negedge clk_sys_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_sys_i);
      rd = 1'b0;
      `CHK(rdata, e)
   endtask
   // upper byte first, lower byte from the latch
   task automatic chk_res(input logic u, input logic [1:0] c, input logic [9:0] e);
      chk_rd({1'b0, u, c, 1'b0}, e[9:2]);
      chk_rd({1'b0, u, c, 1'b1}, {e[1:0], 6'h00});
   endtask
   // cycles until the unit's interrupt shows, capped at maxc
   task automatic wait_irq(input int u, input int maxc, output int cnt);
      cnt = 0;
      while (irq[u] !== 1'b1 && cnt < maxc) begin
         @(negedge clk_sys_i);
         cnt++;
      end
   endtask
   task automatic do_reset(input int cyc);
      @(negedge clk_sys_i);
      sys_rst_i = 1'b1;
      repeat (cyc) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
   endtask
   function automatic logic [9:0] lvl(input logic u, input logic [1:0] c);
      return {u, c, 7'h5A};
   endfunction

   task automatic report_and_stop();
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // hang guard, about six times the expected run
   initial begin
      #200000;
      n_errors++;
      $display("[ERR] %0t %h %h", $time, 1'b0, 1'b1);
      report_and_stop();
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      do_reset(12);
      chk_rd(`DADC_OFS_TRG0, 8'h7F);
      chk_rd(`DADC_OFS_TRG1, 8'h7F);
      chk_rd(`DADC_OFS_CSR1, 8'h00);
      chk_rd(5'h14, 8'h00);
      chk_res(1'b1, 2'h3, 10'h000);
      // register access kinds, then standby initialisation
      wrb(`DADC_OFS_TRG0, 8'hFF);
      chk_rd(`DADC_OFS_TRG0, 8'hFF);
      wrb(`DADC_OFS_TRG0, 8'h7F);
      chk_rd(`DADC_OFS_TRG0, 8'h7F);
      wrb(`DADC_OFS_CSR0, 8'h08);
      chk_rd(`DADC_OFS_CSR0, 8'h08);
      wrb(`DADC_OFS_TRG1, 8'hFF);
      @(negedge clk_sys_i);
      standby = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      standby = 1'b0;
      chk_rd(`DADC_OFS_TRG1, 8'h7F);
      chk_rd(`DADC_OFS_CSR0, 8'h00);
      // scan groups of one to four inputs at speed 1, config set while stopped
      for (int c = 0; c < 4; c++) begin
         do_reset(2);
         wrb(`DADC_OFS_CSR0, 8'h78 | c[7:0]);
         wait_irq(0, 700, n);
         `CHK(n >= 131 + 128 * c && n <= 134 + 128 * c, 1'b1)
         chk_rd(`DADC_OFS_CSR0, 8'hF8 | c[7:0]);
         wrb(`DADC_OFS_CSR0, 8'h78 | c[7:0]);
         wait_irq(0, 700, n);
         `CHK(n + 4 == 128 * (c + 1), 1'b1)
         chk_rd(`DADC_OFS_CSR0, 8'hF8 | c[7:0]);
         wrb(`DADC_OFS_CSR0, 8'h58 | c[7:0]);
         wait_irq(0, 600, n);
         `CHK(n == 600, 1'b1)
         for (int k = 0; k < 4; k++) begin
            chk_res(1'b0, k[1:0], (k <= c) ? lvl(1'b0, k[1:0]) : 10'h000);
         end
      end
      // single conversion at speed 0 and the end flag clear protocol
      wrb(`DADC_OFS_CSR0, 8'h61);
      wait_irq(0, 300, n);
      `CHK(n >= 259 && n <= 266, 1'b1)
      wrb(`DADC_OFS_CSR0, 8'h41);
      `CHK(irq[0], 1'b1)
      chk_rd(`DADC_OFS_CSR0, 8'hC1);
      wrb(`DADC_OFS_CSR0, 8'hC1);
      chk_rd(`DADC_OFS_CSR0, 8'hC1);
      wrb(`DADC_OFS_CSR0, 8'h41);
      chk_rd(`DADC_OFS_CSR0, 8'h41);
      `CHK(irq[0], 1'b0)
      chk_res(1'b0, 2'h1, lvl(1'b0, 2'h1));
      // triggers: ignored while disabled, shared by both units once enabled
      wrb(`DADC_OFS_CSR0, 8'h43);
      wrb(`DADC_OFS_CSR1, 8'h01);
      @(negedge clk_sys_i);
      tmr = 1'b1;
      @(negedge clk_sys_i);
      tmr = 1'b0;
      wait_irq(0, 300, n);
      `CHK(n == 300, 1'b1)
      wrb(`DADC_OFS_TRG1, 8'hFF);
      @(negedge clk_sys_i);
      pin_n = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      pin_n = 1'b1;
      wait_irq(0, 300, n);
      `CHK(n < 300, 1'b1)
      chk_res(1'b0, 2'h3, lvl(1'b0, 2'h3));
      chk_res(1'b1, 2'h1, lvl(1'b1, 2'h1));
      chk_rd(`DADC_OFS_CSR0, 8'hC3);
      wrb(`DADC_OFS_CSR0, 8'h43);
      wrb(`DADC_OFS_TRG1, 8'h7F);
      wrb(`DADC_OFS_TRG0, 8'hFF);
      @(negedge clk_sys_i);
      tmr = 1'b1;
      @(negedge clk_sys_i);
      tmr = 1'b0;
      wait_irq(0, 300, n);
      `CHK(n < 300, 1'b1)
      wrb(`DADC_OFS_TRG0, 8'h7F);
      chk_rd(`DADC_OFS_CSR1, 8'h81);
      wrb(`DADC_OFS_CSR1, 8'h00);
      // unit 1 single mode through every channel code at speed 1
      for (int c = 0; c < 4; c++) begin
         wrb(`DADC_OFS_CSR1, 8'h68 | c[7:0]);
         wait_irq(1, 200, n);
         `CHK(n >= 131 && n <= 134, 1'b1)
         chk_res(1'b1, c[1:0], lvl(1'b1, c[1:0]));
         chk_rd(`DADC_OFS_CSR1, 8'hC8 | c[7:0]);
         wrb(`DADC_OFS_CSR1, 8'h48 | c[7:0]);
         `CHK(irq[1], 1'b0)
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
